//--- hdl/tocc_pkg.sv
package tocc_pkg;

	localparam int          NCH           = 16;
	localparam int          GRP_CH        = 8;
	localparam int          CNT_W         = 16;

	// Address decode: bit 9 splits group and channel space
	localparam int          ADDR_W        = 10;
	localparam int          ADDR_CH_BIT   = 9;
	localparam int          ADDR_GRP_BIT  = 5;
	localparam logic [2:0]  GRP_PAD       = 3'h0;
	// Group register index
	localparam logic [2:0]  IDX_ENABLE    = 3'h0;
	localparam logic [2:0]  IDX_OUT_EN    = 3'h1;
	localparam logic [2:0]  IDX_FORCE_UPD = 3'h2;
	localparam logic [2:0]  IDX_INTERNAL_TRIGGER_SELECT  = 3'h3;
	// Channel register index
	localparam logic [2:0]  IDX_CTRL      = 3'h0;
	localparam logic [2:0]  IDX_COUNTER   = 3'h1;
	localparam logic [2:0]  IDX_PERIOD    = 3'h2;
	localparam logic [2:0]  IDX_DUTY      = 3'h3;
	localparam logic [2:0]  IDX_PERIOD_SH = 3'h4;
	localparam logic [2:0]  IDX_DUTY_SH   = 3'h5;

	// Channel control fields, bit 0 is the least significant bit
	localparam int          CTRL_LEVEL    = 11;
	localparam int          CTRL_CLK_LSB  = 12;
	localparam int          CTRL_RST_SRC  = 20;
	localparam int          CTRL_TRIG_OUT = 24;
	localparam int          CTRL_ONE_SHOT = 26;
	localparam int          CTRL_SENSOR   = 28;
	localparam int          CTRL_GATED    = 29;
	localparam logic [31:0] CTRL_WR_MASK  = 32'h3510_7800;
	localparam logic [31:0] CTRL_SENS_MSK = 32'h3000_0000;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

	localparam logic [1:0]  FLD_CLEAR     = 2'h1;
	localparam logic [1:0]  FLD_SET       = 2'h2;
	localparam logic [1:0]  FLD_ON        = 2'h3;
	localparam logic [2:0]  CLK_MAX       = 3'h4;
	localparam logic [2:0]  CLK_RESET     = 3'h0;
	localparam logic [15:0] GRP_RESET     = 16'h0000;
	localparam logic [15:0] CNT_RESET     = 16'h0000;
	localparam int          SENSOR_CH     = 2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} tocc_bus_req_t;

	typedef struct packed {
		logic [NCH-1:0] pin;
		logic [NCH-1:0] trig;
	} tocc_chan_out_t;

	// Two-bit fields: 01 clears to 00, 10 sets to 11, others keep
	function automatic logic [15:0] tocc_fields(input logic [15:0] old_v, input logic [15:0] wr_v);
		logic [15:0] r;
		r = old_v;
		for (int i = 0; i < GRP_CH; i++) begin
			if (wr_v[2*i +: 2] == FLD_CLEAR) begin
				r[2*i +: 2] = 2'h0;
			end else if (wr_v[2*i +: 2] == FLD_SET) begin
				r[2*i +: 2] = FLD_ON;
			end
		end
		return r;
	endfunction : tocc_fields

endpackage : tocc_pkg

//--- hdl/tocc_channel_control.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tocc_channel_control #(
	parameter logic [15:0] LEVEL_RESET      = 16'h0000,
	parameter logic        SENSOR_CONNECTED = 1'b1
) (
	// Clock and reset
	input  wire logic                    core_clk_in,
	input  wire logic                    reset_n_in,
	// Register port
	input  wire tocc_pkg::tocc_bus_req_t bus_in,
	output logic [31:0]                  rdata_out,
	// Divided clock ticks and chain trigger
	input  wire logic [4:0]              fx_tick_in,
	input  wire logic                    trig_in,
	// Sensor pattern module
	input  wire logic                    new_pattern_in,
	input  wire logic                    sensor_gate_in,
	// Channel pins and triggers
	output tocc_pkg::tocc_chan_out_t     chan_out,
	output logic [1:0]                   group_trigger_out
);
	import tocc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic grp_hit(input tocc_bus_req_t b, input logic g, input logic [2:0] idx);
		return b.wr && !b.addr[ADDR_CH_BIT] && (b.addr[8:6] == GRP_PAD)
			&& (b.addr[ADDR_GRP_BIT] == g) && (b.addr[4:2] == idx);
	endfunction : grp_hit

	function automatic logic ch_hit(input tocc_bus_req_t b, input logic [3:0] c, input logic [2:0] idx);
		return b.wr && b.addr[ADDR_CH_BIT] && (b.addr[8:5] == c) && (b.addr[4:2] == idx);
	endfunction : ch_hit

	function automatic logic pick_tick(input logic [4:0] t, input logic [2:0] s);
		logic r;
		r = 1'b0;
		case (s)
			3'h0:    r = t[0];
			3'h1:    r = t[1];
			3'h2:    r = t[2];
			3'h3:    r = t[3];
			3'h4:    r = t[4];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pick_tick

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [31:0]      ctrl_q    [NCH];
	logic [2:0]       clk_act_q [NCH];
	logic [CNT_W-1:0] cnt_q     [NCH];
	logic [CNT_W-1:0] per_q     [NCH];
	logic [CNT_W-1:0] duty_q    [NCH];
	logic [CNT_W-1:0] per_sh_q  [NCH];
	logic [CNT_W-1:0] duty_sh_q [NCH];
	logic [NCH-1:0]   os_run_q;
	logic [15:0]      en_q      [2];
	logic [15:0]      oen_q     [2];
	logic [15:0]      fupd_q    [2];
	logic [15:0]      itrig_q   [2];
	logic [31:0]      rdata_q;
	logic [31:0]      rdata_d;
	logic [NCH-1:0]   pin_q;

	logic [NCH-1:0]   chain;
	logic [NCH-1:0]   prev_trig;
	logic [NCH-1:0]   clr;
	logic [NCH-1:0]   adv;
	logic [NCH-1:0]   upd;
	logic [NCH-1:0]   fupd_pulse;
	logic [NCH-1:0]   os_start;
	logic [NCH-1:0]   pin;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel datapath

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam int G = c / GRP_CH;
		localparam int F = c % GRP_CH;
		logic ch_en;
		logic out_en;
		logic clk_ok;
		logic gate_ok;
		logic run;
		logic match;
		logic nipd;
		logic active;

		assign ch_en   = en_q[G][2*F+1];
		assign out_en  = oen_q[G][2*F+1];
		// codes above four stop the clock
		assign clk_ok  = clk_act_q[c] <= CLK_MAX;
		// gated count follows the sensor gate
		assign gate_ok = !ctrl_q[c][CTRL_GATED] || sensor_gate_in;
		// one-shot counts only while its period is armed
		assign run     = ch_en && gate_ok && (!ctrl_q[c][CTRL_ONE_SHOT] || os_run_q[c]);
		// advance on the selected divided tick
		assign adv[c]  = run && clk_ok && pick_tick(fx_tick_in, clk_act_q[c]);
		assign match   = adv[c] && (cnt_q[c] >= per_q[c]);
		assign nipd    = (c == SENSOR_CH) && ctrl_q[c][CTRL_SENSOR] && new_pattern_in;

		if (c == 0) begin : g_first
			assign prev_trig[c] = trig_in;
		end else begin : g_next
			assign prev_trig[c] = chain[c-1];
		end

		// clear source: period match or previous trigger
		// new pattern clears regardless of source bit
		assign clr[c] = (ctrl_q[c][CTRL_RST_SRC] ? (prev_trig[c] && ch_en) : match) || nipd;
		// outgoing trigger: pass through or own clear event
		assign chain[c] = ctrl_q[c][CTRL_TRIG_OUT] ? clr[c] : prev_trig[c];
		// forced update from group field written with the set code
		assign fupd_pulse[c] = grp_hit(bus_in, 1'(G), IDX_FORCE_UPD)
			&& (bus_in.wdata[2*F +: 2] == FLD_SET);
		// shadow update at period end or forced
		assign upd[c] = clr[c] || fupd_pulse[c];
		// counter write or sensor pattern starts a single pulse
		assign os_start[c] = ch_hit(bus_in, 4'(c), IDX_COUNTER)
			|| (nipd && ctrl_q[c][CTRL_ONE_SHOT]);

		// duty level while enabled, inverse level otherwise
		assign active = out_en && ch_en && (cnt_q[c] < duty_q[c]);
		assign pin[c] = active ? ctrl_q[c][CTRL_LEVEL] : !ctrl_q[c][CTRL_LEVEL];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel control registers

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int c = 0; c < NCH; c++) begin
				// level bit reset from build parameter
				ctrl_q[c] <= CTRL_RESET | (32'(LEVEL_RESET[c]) << CTRL_LEVEL);
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (ch_hit(bus_in, 4'(c), IDX_CTRL)) begin
					// sensor and gated bits only on low channels
					if (SENSOR_CONNECTED && c < GRP_CH) begin
						ctrl_q[c] <= bus_in.wdata & CTRL_WR_MASK;
					end else begin
						ctrl_q[c] <= bus_in.wdata & CTRL_WR_MASK & ~CTRL_SENS_MSK;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operating and shadow compare registers, active clock select

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int c = 0; c < NCH; c++) begin
				clk_act_q[c] <= CLK_RESET;
				per_q[c]     <= CNT_RESET;
				duty_q[c]    <= CNT_RESET;
				per_sh_q[c]  <= CNT_RESET;
				duty_sh_q[c] <= CNT_RESET;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (ch_hit(bus_in, 4'(c), IDX_PERIOD_SH)) begin
					per_sh_q[c] <= bus_in.wdata[CNT_W-1:0];
				end
				if (ch_hit(bus_in, 4'(c), IDX_DUTY_SH)) begin
					duty_sh_q[c] <= bus_in.wdata[CNT_W-1:0];
				end
				// a stopped channel leaves this state only here
				if (upd[c]) begin
					per_q[c]     <= per_sh_q[c];
					duty_q[c]    <= duty_sh_q[c];
					clk_act_q[c] <= ctrl_q[c][CTRL_CLK_LSB +: 3];
				end else begin
					if (ch_hit(bus_in, 4'(c), IDX_PERIOD)) begin
						per_q[c] <= bus_in.wdata[CNT_W-1:0];
					end
					if (ch_hit(bus_in, 4'(c), IDX_DUTY)) begin
						duty_q[c] <= bus_in.wdata[CNT_W-1:0];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counters and one-shot state

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int c = 0; c < NCH; c++) begin
				cnt_q[c] <= CNT_RESET;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (ch_hit(bus_in, 4'(c), IDX_COUNTER)) begin
					cnt_q[c] <= bus_in.wdata[CNT_W-1:0];
				end else if (clr[c]) begin
					cnt_q[c] <= CNT_RESET;
				// no advance while disabled, and no clear except by a new pattern
				end else if (adv[c]) begin
					cnt_q[c] <= cnt_q[c] + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			os_run_q <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				// start wins over the end of the period
				if (os_start[c]) begin
					os_run_q[c] <= 1'b1;
				end else if (clr[c]) begin
					os_run_q[c] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger group registers, low group and high group

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int g = 0; g < 2; g++) begin
				en_q[g]    <= GRP_RESET;
				oen_q[g]   <= GRP_RESET;
				fupd_q[g]  <= GRP_RESET;
				itrig_q[g] <= GRP_RESET;
			end
		end else begin
			for (int g = 0; g < 2; g++) begin
				if (grp_hit(bus_in, 1'(g), IDX_ENABLE)) begin
					en_q[g] <= tocc_fields(en_q[g], bus_in.wdata[15:0]);
				end
				if (grp_hit(bus_in, 1'(g), IDX_OUT_EN)) begin
					oen_q[g] <= tocc_fields(oen_q[g], bus_in.wdata[15:0]);
				end
				if (grp_hit(bus_in, 1'(g), IDX_FORCE_UPD)) begin
					fupd_q[g] <= tocc_fields(fupd_q[g], bus_in.wdata[15:0]);
				end
				if (grp_hit(bus_in, 1'(g), IDX_INTERNAL_TRIGGER_SELECT)) begin
					itrig_q[g] <= tocc_fields(itrig_q[g], bus_in.wdata[15:0]);
				end
			end
		end
	end

	// group trigger gathers the selected channel triggers
	always_comb begin
		group_trigger_out = 2'h0;
		for (int c = 0; c < NCH; c++) begin
			if (itrig_q[c / GRP_CH][2*(c % GRP_CH)+1] && chain[c]) begin
				group_trigger_out[c / GRP_CH] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path, data one cycle after the strobe

	always_comb begin
		logic [3:0] ch;
		ch      = bus_in.addr[8:5];
		rdata_d = 32'h0000_0000;
		if (bus_in.addr[ADDR_CH_BIT]) begin
			case (bus_in.addr[4:2])
				IDX_CTRL:      rdata_d = ctrl_q[ch];
				IDX_COUNTER:   rdata_d = {16'h0000, cnt_q[ch]};
				IDX_PERIOD:    rdata_d = {16'h0000, per_q[ch]};
				IDX_DUTY:      rdata_d = {16'h0000, duty_q[ch]};
				IDX_PERIOD_SH: rdata_d = {16'h0000, per_sh_q[ch]};
				IDX_DUTY_SH:   rdata_d = {16'h0000, duty_sh_q[ch]};
				default:       rdata_d = 32'h0000_0000;
			endcase
		end else if (bus_in.addr[8:6] == GRP_PAD) begin
			// upper half of group words reads zero
			case (bus_in.addr[4:2])
				IDX_ENABLE:    rdata_d = {16'h0000, en_q[bus_in.addr[ADDR_GRP_BIT]]};
				IDX_OUT_EN:    rdata_d = {16'h0000, oen_q[bus_in.addr[ADDR_GRP_BIT]]};
				IDX_FORCE_UPD: rdata_d = {16'h0000, fupd_q[bus_in.addr[ADDR_GRP_BIT]]};
				IDX_INTERNAL_TRIGGER_SELECT:  rdata_d = {16'h0000, itrig_q[bus_in.addr[ADDR_GRP_BIT]]};
				default:       rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_in.rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_q <= '0;
		end else begin
			pin_q <= pin;
		end
	end

	// One driver for the whole carrier: registered pins, combinational triggers
	assign chan_out      = '{pin: pin_q, trig: chain};
	assign rdata_out     = rdata_q;

endmodule : tocc_channel_control

`default_nettype wire

//--- test/tocc_channel_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module tocc_monitor #(
	parameter logic [15:0] LEVEL_RESET = 16'h0000
) (
	// Clock and reset
	input wire logic                     core_clk_in,
	input wire logic                     reset_n_in,
	// Register port
	input wire tocc_pkg::tocc_bus_req_t  bus_in,
	input wire logic [31:0]              rdata_out,
	// Channel side
	input wire logic [4:0]               fx_tick_in,
	input wire logic                     trig_in,
	input wire logic                     new_pattern_in,
	input wire logic                     sensor_gate_in,
	input wire tocc_pkg::tocc_chan_out_t chan_out,
	input wire logic [1:0]               group_trigger_out
);
	import tocc_pkg::*;

	logic lvl0_q;
	logic tout0_q;
	logic oen0_q;
	logic grp_rd;
	assign grp_rd = bus_in.rd && !bus_in.addr[ADDR_CH_BIT] && bus_in.addr[4:2] <= IDX_INTERNAL_TRIGGER_SELECT;

	// Channel 0 level and trigger-out as last written
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lvl0_q <= LEVEL_RESET[0];
			tout0_q <= 1'b0;
		end else if (bus_in.wr && bus_in.addr[9:2] == 8'h80) begin
			lvl0_q <= bus_in.wdata[CTRL_LEVEL];
			tout0_q <= bus_in.wdata[CTRL_TRIG_OUT];
		end
	end

	// Channel 0 output enable as last written
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			oen0_q <= 1'b0;
		end else if (bus_in.wr && bus_in.addr[9:2] == 8'h01) begin
			if (bus_in.wdata[1:0] == FLD_SET) begin
				oen0_q <= 1'b1;
			end else if (bus_in.wdata[1:0] == FLD_CLEAR) begin
				oen0_q <= 1'b0;
			end
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	chk_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 32'h0)
		else $error("read data not zero outside a read");
	chk_trig_reserved: assert property (grp_rd |=> rdata_out[31:16] == 16'h0)
		else $error("group reserved bits not zero");
	chk_ctrl_reserved: assert property (bus_in.rd && bus_in.addr[ADDR_CH_BIT] &&
		bus_in.addr[4:2] == IDX_CTRL |=> (rdata_out & ~CTRL_WR_MASK) == 32'h0)
		else $error("control reserved bits not zero");
	chk_field_pairs: assert property (grp_rd |=>
		((rdata_out[15:0] ^ (rdata_out[15:0] >> 1)) & 16'h5555) == 16'h0)
		else $error("two-bit field reads neither 00 nor 11");
	chk_group_low: assert property (group_trigger_out[0] |-> |chan_out.trig[7:0])
		else $error("low group trigger without channel trigger");
	chk_group_high: assert property (group_trigger_out[1] |-> |chan_out.trig[15:8])
		else $error("high group trigger without channel trigger");
	chk_trig_pass: assert property (!tout0_q |-> chan_out.trig[0] == trig_in)
		else $error("chain trigger not passed through");
	chk_pin_idle: assert property (!oen0_q && !$past(oen0_q) && $stable(lvl0_q) &&
		$past(reset_n_in) |-> chan_out.pin[0] == !lvl0_q)
		else $error("disabled pin not inverse of level");
	chk_level_read: assert property (bus_in.rd && bus_in.addr[9:2] == 8'h80 |=>
		rdata_out[CTRL_LEVEL] == lvl0_q)
		else $error("level bit read back wrong");

endmodule : tocc_monitor

`default_nettype wire

//--- test/test_tocc_channel_control.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, e); end end

module test_tocc_channel_control;
	import tocc_pkg::*;

	logic                 clk;
	logic                 rst_n;
	tocc_bus_req_t        bus;
	logic [31:0]          rdata;
	logic [4:0]           fx;
	logic                 ti;
	logic                 np;
	logic                 gate;
	tocc_chan_out_t       co;
	logic [1:0]           gto;
	int                   n_fail;
	int                   cmp_count;
	int                   cyc;

	tocc_channel_control #(.LEVEL_RESET(16'h0001)) DUT (
		.core_clk_in(clk), .reset_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
		.fx_tick_in(fx), .trig_in(ti), .new_pattern_in(np), .sensor_gate_in(gate),
		.chan_out(co), .group_trigger_out(gto)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			final_report();
		end
	end

	task final_report;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rchk(input logic [9:0] a, input logic [31:0] e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		`CHK(rdata, e)
		@(posedge clk);
	endtask : rchk

	task automatic tk(input logic [4:0] m);
		fx <= m;
		@(posedge clk);
		fx <= 5'h0;
		@(posedge clk);
	endtask : tk

	task automatic t_regs;
		rchk(10'h200, 32'h0000_0800);
		rchk(10'h220, 32'h0);
		wr(10'h220, 32'hffff_ffff);
		rchk(10'h220, CTRL_WR_MASK);
		wr(10'h220, 32'h0);
		wr(10'h300, 32'hffff_ffff);
		rchk(10'h300, CTRL_WR_MASK & ~CTRL_SENS_MSK);
		wr(10'h300, 32'h0);
		rchk(10'h3f8, 32'h0);
	endtask : t_regs

	task automatic t_fields;
		logic [9:0] a;
		for (int g = 0; g < 2; g++) begin
			a = (g == 0) ? 10'h00c : 10'h02c;
			rchk(a, 32'h0);
			wr(a, 32'h0000_aaaa);
			rchk(a, 32'h0000_ffff);
			wr(a, 32'hffff_4e4e);
			rchk(a, 32'h0000_3f3f);
		end
	endtask : t_fields

	task automatic t_count;
		wr(10'h210, 32'h2);
		wr(10'h200, 32'h0100_0800);
		wr(10'h008, 32'h2);
		wr(10'h000, 32'h2);
		tk(5'h01);
		tk(5'h01);
		rchk(10'h204, 32'h2);
		tk(5'h02);
		rchk(10'h204, 32'h2);
		fx <= 5'h01;
		@(negedge clk);
		`CHK(co.trig[0], 1'b1)
		@(posedge clk);
		fx <= 5'h0;
		@(posedge clk);
		rchk(10'h204, 32'h0);
	endtask : t_count

	task automatic t_stop;
		wr(10'h200, 32'h0100_5800);
		tk(5'h01);
		rchk(10'h204, 32'h1);
		wr(10'h008, 32'h2);
		tk(5'h1f);
		tk(5'h1f);
		rchk(10'h204, 32'h1);
		wr(10'h200, 32'h0100_0800);
		tk(5'h01);
		rchk(10'h204, 32'h1);
		wr(10'h008, 32'h2);
		tk(5'h01);
		rchk(10'h204, 32'h2);
		wr(10'h000, 32'h1);
		tk(5'h01);
		rchk(10'h204, 32'h2);
		wr(10'h000, 32'h2);
		rchk(10'h204, 32'h2);
	endtask : t_stop

	task automatic t_chain;
		wr(10'h200, 32'h0010_0800);
		ti <= 1'b1;
		@(negedge clk);
		`CHK(co.trig[0], 1'b1)
		`CHK(gto[0], 1'b1)
		`CHK(gto[1], 1'b1)
		@(posedge clk);
		ti <= 1'b0;
		@(posedge clk);
		rchk(10'h204, 32'h0);
	endtask : t_chain

	task automatic t_pin;
		@(negedge clk);
		`CHK(co.pin[1:0], 2'b10)
		@(posedge clk);
		wr(10'h20c, 32'h3);
		wr(10'h004, 32'h2);
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK(co.pin[0], 1'b1)
		@(posedge clk);
	endtask : t_pin

	task automatic t_sens;
		wr(10'h240, 32'h1000_0000);
		wr(10'h000, 32'h20);
		wr(10'h244, 32'h5);
		np <= 1'b1;
		@(posedge clk);
		np <= 1'b0;
		@(posedge clk);
		rchk(10'h244, 32'h0);
	endtask : t_sens

	task automatic t_one;
		wr(10'h250, 32'h2);
		wr(10'h240, 32'h1400_0000);
		tk(5'h01);
		rchk(10'h244, 32'h0);
		np <= 1'b1;
		@(posedge clk);
		np <= 1'b0;
		@(posedge clk);
		tk(5'h01);
		rchk(10'h244, 32'h1);
		tk(5'h01);
		tk(5'h01);
		tk(5'h01);
		rchk(10'h244, 32'h0);
		wr(10'h244, 32'h0);
		tk(5'h01);
		rchk(10'h244, 32'h1);
	endtask : t_one

	task automatic t_gate;
		wr(10'h240, 32'h2000_0000);
		tk(5'h01);
		rchk(10'h244, 32'h1);
		gate <= 1'b1;
		tk(5'h01);
		rchk(10'h244, 32'h2);
	endtask : t_gate

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		bus = '0;
		fx = 5'h0;
		ti = 1'b0;
		np = 1'b0;
		gate = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_fields();
		t_count();
		t_stop();
		t_chain();
		t_pin();
		t_sens();
		t_one();
		t_gate();
		final_report();
	end

endmodule : test_tocc_channel_control

bind tocc_channel_control tocc_monitor #(.LEVEL_RESET(LEVEL_RESET)) u_mon (
	.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in),
	.rdata_out(rdata_out), .fx_tick_in(fx_tick_in), .trig_in(trig_in),
	.new_pattern_in(new_pattern_in), .sensor_gate_in(sensor_gate_in),
	.chan_out(chan_out), .group_trigger_out(group_trigger_out)
);

`default_nettype wire
